// ===== scs_defs.svh
// Register offsets, field positions and reset values of the serial control and status block.
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH
`define SCS_OFF_CTRL2    4'h0
`define SCS_OFF_STAT1    4'h4
`define SCS_OFF_DATA     4'h8
`define SCS_OFF_CTRL1    4'hc
`define SCS_ADDR_W       4
`define SCS_B_TIE        7
`define SCS_B_TX_COMPLETE_IRQ_ENABLE       6
`define SCS_B_RIE        5
`define SCS_B_TE         3
`define SCS_B_RE         2
`define SCS_B_RWU        1
`define SCS_B_SBK        0
`define SCS_B_TX_BUFFER_EMPTY       7
`define SCS_B_TC         6
`define SCS_B_RX_BUFFER_FULL       5
`define SCS_B_WAKE       3
`define SCS_B_LOOP_MODE_SELECT      2
`define SCS_B_LONG_BREAK_SELECT      1
`define SCS_B_M9         0
`define SCS_CTRL2_RST    8'h00
`define SCS_CTRL1_RST    8'h00
`define SCS_BRK_SHORT    5'h0a
`define SCS_BRK_LONG     5'h0d
`define SCS_IDLE_BITS    5'h0a
`endif

// ===== scs_pkg.sv
// Types shared by the serial control and status block.
package scs_pkg;
	typedef enum logic [1:0] {
		SCS_TX_IDLE  = 2'b00,
		SCS_TX_DATA  = 2'b01,
		SCS_TX_BREAK = 2'b10,
		SCS_TX_PRE   = 2'b11
	} scs_tx_state_t;
endpackage

// ===== scs_ctrl.sv
// Control and status logic of an asynchronous serial interface with a Wishbone slave.
// Notes on behaviour
// - Receiver off releases the receive pin to general-purpose use.
// - Loop mode releases the receive pin even when the receiver is on.
// - Writing one to standby request puts the receiver into standby awaiting wakeup.
// - Wake method clear wakes on idle line; set wakes on data MSB one.
// - Software sets standby request; hardware clears it on the wakeup condition.
// - Writing break queue one queues a break character; writing it back to zero queues another.
// - Breaks repeat while break queue stays set; 10/11 or 13/14 bit times.
// - A second break may be queued before software clears break queue.
// - Primary status holds three read-only flags; writes have no effect.
// - Transmit-empty sets out of reset and when buffer moves to shifter.
// - Transmit-empty clears after status read with it set, then data write.
// - Transmit-complete sets out of reset and when nothing is being sent.
// - Transmit-complete clears after status read then data write, preamble or break.
// - Receive-full sets when a character moves into the receive data register.
// - Receive-full clears after status read with it set, then data read.
// - Each flag with its enable set requests the interrupt.
// - Transmitter-on off then on while active queues an idle character.
// - Long-break option picks 10 or 13 bit times, plus one for nine-bit frames.
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module scs_ctrl (
	input  wire logic       ref_clk,       // Module bus clock, 25 MHz.
	input  wire logic       nrst,          // Asynchronous reset, active low.
	input  wire logic       wb_cyc_i,      // Wishbone cycle.
	input  wire logic       wb_stb_i,      // Wishbone strobe.
	input  wire logic       wb_we_i,       // Wishbone write enable.
	input  wire logic [3:0] wb_adr_i,      // Wishbone byte address.
	input  wire logic [3:0] wb_sel_i,      // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i,     // Wishbone write data.
	output logic [31:0]     wb_dat_o,      // Wishbone read data.
	output logic            wb_ack_o,      // Wishbone acknowledge.
	input  wire logic       bit_tick,      // One-cycle pulse per bit time from the baud logic.
	input  wire logic       shifter_load,  // Shifter takes the buffered transmit byte.
	input  wire logic       shifter_busy,  // Frame shifter is sending a data frame.
	input  wire logic       rx_char_done,  // Receive shifter holds a completed character.
	input  wire logic [8:0] rx_char,       // Character from the receive shifter.
	input  wire logic       rx_line,       // Receive pin level, asynchronous.
	output logic [7:0]      tx_data,       // Transmit buffer towards the shifter.
	output logic            tx_send_break, // Line is driving a break character.
	output logic            tx_send_idle,  // Line is driving an idle preamble.
	output logic            tx_pin_owned,  // Transmitter owns the transmit pin.
	output logic            rx_pin_owned,  // Receiver owns the receive pin.
	output logic            rx_standby,    // Receiver is in standby.
	output logic            irq            // Level interrupt request, active high.
);
	logic [7:0] ctrl2;
	logic [7:0] ctrl1;
	logic [7:0] irq_stat;
	logic [7:0] irq_mask;
	logic [8:0] rx_data;
	logic       tx_buffer_empty;
	logic       tc;
	logic       rx_buffer_full;
	logic       arm_tx_buffer_empty;
	logic       arm_tc;
	logic       arm_rx_buffer_full;
	logic       tx_full;
	logic       brk_pend;
	logic       pre_pend;
	logic [4:0] bit_cnt;
	logic       rx_s1;
	logic       rx_s2;
	logic [4:0] idle_cnt;
	scs_pkg::scs_tx_state_t tx_st;
	scs_pkg::scs_tx_state_t next_tx_st;

	logic       acc;
	logic       wr;
	logic       rd;
	logic       wr_ctrl2;
	logic       rd_stat;
	logic       wr_data;
	logic       rd_data;
	logic [7:0] wbyte;
	logic [7:0] stat1;
	logic       te_rise;
	logic       sbk_set;
	logic       sbk_fall;
	logic       wake_hit;
	logic [4:0] brk_len;
	logic       tx_active;

	// Only a fresh request is answered, so every access is exactly one cycle wide.
	assign acc      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr       = acc && wb_we_i && wb_sel_i[0];
	assign rd       = acc && !wb_we_i;
	assign wbyte    = wb_dat_i[7:0];
	assign wr_ctrl2 = wr && (wb_adr_i == `SCS_OFF_CTRL2);
	assign wr_data  = wr && (wb_adr_i == `SCS_OFF_DATA);
	assign rd_stat  = rd && (wb_adr_i == `SCS_OFF_STAT1);
	assign rd_data  = rd && (wb_adr_i == `SCS_OFF_DATA);
	assign te_rise  = wr_ctrl2 && wbyte[`SCS_B_TE] && !ctrl2[`SCS_B_TE];
	assign sbk_set  = wr_ctrl2 && wbyte[`SCS_B_SBK];
	assign sbk_fall = wr_ctrl2 && !wbyte[`SCS_B_SBK] && ctrl2[`SCS_B_SBK];
	assign stat1    = {tx_buffer_empty, tc, rx_buffer_full, 5'h00};
	assign tx_active = (tx_st != scs_pkg::SCS_TX_IDLE) || shifter_busy || tx_full;

	// Break length in bit times, one longer for nine-bit frames.
	function automatic logic [4:0] break_bits(input logic long_sel, input logic nine);
		break_bits = (long_sel ? `SCS_BRK_LONG : `SCS_BRK_SHORT) + {4'h0, nine};
	endfunction
	assign brk_len = break_bits(ctrl1[`SCS_B_LONG_BREAK_SELECT], ctrl1[`SCS_B_M9]);

	// Two flip-flops on the asynchronous receive pin.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rx_line;
			rx_s2 <= rx_s1;
		end
	end

	// Idle-line counter for wakeup; counts high bit times, restarts on any low.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			idle_cnt <= 5'h00;
		end else if (!rx_s2) begin
			idle_cnt <= 5'h00;
		end else if (bit_tick && idle_cnt != `SCS_IDLE_BITS) begin
			idle_cnt <= idle_cnt + 5'h01;
		end
	end

	always_comb begin
		if (ctrl1[`SCS_B_WAKE]) begin
			wake_hit = rx_char_done && (ctrl1[`SCS_B_M9] ? rx_char[8] : rx_char[7]);
		end else begin
			wake_hit = bit_tick && (idle_cnt == `SCS_IDLE_BITS - 5'h01) && rx_s2;
		end
	end

	// Control register 2; the standby bit is cleared by the wakeup detector.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl2 <= `SCS_CTRL2_RST;
		end else begin
			if (wr_ctrl2) begin
				ctrl2 <= wbyte;
			end
			if (ctrl2[`SCS_B_RWU] && wake_hit && !(wr_ctrl2 && wbyte[`SCS_B_RWU])) begin
				ctrl2[`SCS_B_RWU] <= 1'b0;
			end
		end
	end

	// Control register 1 holds wake method, loop, long-break and nine-bit selects.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl1 <= `SCS_CTRL1_RST;
		end else if (wr && wb_adr_i == `SCS_OFF_CTRL1) begin
			ctrl1 <= wbyte;
		end
	end

	// Transmit buffer: a data write fills it, the shifter empties it.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_full <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			if (wr_data) begin
				tx_data <= wbyte;
			end
			if (wr_data && arm_tx_buffer_empty) begin
				tx_full <= 1'b1;
			end else if (shifter_load) begin
				tx_full <= 1'b0;
			end
		end
	end

	// Transmit-empty flag; the shifter load wins over a clearing write.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_buffer_empty     <= 1'b1;
			arm_tx_buffer_empty <= 1'b0;
		end else begin
			if (shifter_load) begin
				tx_buffer_empty <= 1'b1;
			end else if (wr_data && arm_tx_buffer_empty) begin
				tx_buffer_empty <= 1'b0;
			end
			if (rd_stat) begin
				arm_tx_buffer_empty <= tx_buffer_empty;
			end else if (wr_data) begin
				arm_tx_buffer_empty <= 1'b0;
			end
		end
	end

	// Transmit-complete flag; set whenever the transmitter has nothing left to send.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tc     <= 1'b1;
			arm_tc <= 1'b0;
		end else begin
			if (arm_tc && (wr_data || te_rise || sbk_set)) begin
				tc <= 1'b0;
			end else if (tx_buffer_empty && !tx_active && !brk_pend && !pre_pend) begin
				tc <= 1'b1;
			end
			if (rd_stat) begin
				arm_tc <= tc;
			end else if (wr_data || te_rise || sbk_set) begin
				arm_tc <= 1'b0;
			end
		end
	end

	// Receive data register and its full flag; a new character wins over the clear.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_buffer_full     <= 1'b0;
			arm_rx_buffer_full <= 1'b0;
			rx_data  <= 9'h000;
		end else begin
			if (rx_char_done && !ctrl2[`SCS_B_RWU]) begin
				rx_buffer_full    <= 1'b1;
				rx_data <= rx_char;
			end else if (rd_data && arm_rx_buffer_full) begin
				rx_buffer_full <= 1'b0;
			end
			if (rd_stat) begin
				arm_rx_buffer_full <= rx_buffer_full;
			end else if (rd_data) begin
				arm_rx_buffer_full <= 1'b0;
			end
		end
	end

	// Pending break and idle requests wait for the line to be free.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			brk_pend <= 1'b0;
			pre_pend <= 1'b0;
		end else begin
			if (sbk_fall || sbk_set) begin
				brk_pend <= 1'b1;
			end else if (next_tx_st == scs_pkg::SCS_TX_BREAK && tx_st != scs_pkg::SCS_TX_BREAK) begin
				brk_pend <= 1'b0;
			end
			if (te_rise) begin
				pre_pend <= 1'b1;
			end else if (next_tx_st == scs_pkg::SCS_TX_PRE) begin
				pre_pend <= 1'b0;
			end
		end
	end

	// Line sequencer: data frames belong to the shifter, breaks and idles are timed here.
	always_comb begin
		next_tx_st = tx_st;
		unique case (tx_st)
			scs_pkg::SCS_TX_IDLE: begin
				if (shifter_busy) begin
					next_tx_st = scs_pkg::SCS_TX_DATA;
				end else if (brk_pend || ctrl2[`SCS_B_SBK]) begin
					next_tx_st = scs_pkg::SCS_TX_BREAK;
				end else if (pre_pend) begin
					next_tx_st = scs_pkg::SCS_TX_PRE;
				end
			end
			scs_pkg::SCS_TX_DATA: begin
				if (!shifter_busy) begin
					next_tx_st = scs_pkg::SCS_TX_IDLE;
				end
			end
			scs_pkg::SCS_TX_BREAK, scs_pkg::SCS_TX_PRE: begin
				// A break still requested at its end runs again, hence a possible second one.
				if (bit_tick && bit_cnt == brk_len - 5'h01) begin
					next_tx_st = scs_pkg::SCS_TX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_st   <= scs_pkg::SCS_TX_IDLE;
			bit_cnt <= 5'h00;
		end else begin
			tx_st <= next_tx_st;
			if (next_tx_st != tx_st) begin
				bit_cnt <= 5'h00;
			end else if (bit_tick) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// Pin ownership, line drive and standby, all registered.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tx_send_break <= 1'b0;
			tx_send_idle  <= 1'b0;
			tx_pin_owned  <= 1'b0;
			rx_pin_owned  <= 1'b0;
			rx_standby    <= 1'b0;
		end else begin
			tx_send_break <= (next_tx_st == scs_pkg::SCS_TX_BREAK);
			tx_send_idle  <= (next_tx_st == scs_pkg::SCS_TX_PRE);
			tx_pin_owned  <= ctrl2[`SCS_B_TE] || tx_active;
			rx_pin_owned  <= ctrl2[`SCS_B_RE] && !ctrl1[`SCS_B_LOOP_MODE_SELECT];
			rx_standby    <= ctrl2[`SCS_B_RWU];
		end
	end

	// Sticky interrupt status, cleared by a read of control register 1; a new event in that cycle wins.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= 8'h00;
			irq_mask <= 8'h00;
			irq      <= 1'b0;
		end else begin
			// Sticky status shares the control one read decode, the mask shares control two.
			irq_stat <= (rd && wb_adr_i == `SCS_OFF_CTRL1 ? 8'h00 : irq_stat)
				| (stat1 & ctrl2 & 8'he0);
			if (wr && wb_adr_i == `SCS_OFF_CTRL2) begin
				irq_mask <= wbyte;
			end
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Bus answer one cycle after the request; unmapped offsets read zero and are acked.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= 32'h0000_0000;
			if (rd) begin
				unique case (wb_adr_i)
					`SCS_OFF_CTRL2: wb_dat_o <= {24'h000000, ctrl2};
					`SCS_OFF_STAT1: wb_dat_o <= {24'h000000, stat1};
					`SCS_OFF_DATA:  wb_dat_o <= {23'h000000, rx_data};
					`SCS_OFF_CTRL1: wb_dat_o <= {24'h000000, ctrl1};
					default:        wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== scs_checker.sv
// Port assertions for the serial control and status block.
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module scs_checker (
	input wire logic        ref_clk,       // Bus clock.
	input wire logic        nrst,          // Reset, active low.
	input wire logic        wb_cyc_i,      // Cycle.
	input wire logic        wb_stb_i,      // Strobe.
	input wire logic        wb_we_i,       // Write enable.
	input wire logic [3:0]  wb_adr_i,      // Address.
	input wire logic [3:0]  wb_sel_i,      // Byte selects.
	input wire logic [31:0] wb_dat_i,      // Write data.
	input wire logic [31:0] wb_dat_o,      // Read data.
	input wire logic        wb_ack_o,      // Acknowledge.
	input wire logic        rx_char_done,  // Character ready.
	input wire logic [8:0]  rx_char,       // Character.
	input wire logic        tx_send_break, // Break on line.
	input wire logic        tx_pin_owned,  // Transmit pin held.
	input wire logic        rx_pin_owned,  // Receive pin held.
	input wire logic        rx_standby     // Receiver standby.
);
	logic       req;
	logic       wr;
	logic       msb;
	logic [7:0] c2;
	logic [7:0] c1;
	logic [1:0] age;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign msb = c1[`SCS_B_M9] ? rx_char[8] : rx_char[7];
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			c2 <= 8'h00;
			c1 <= 8'h00;
		end else if (wr && wb_adr_i == `SCS_OFF_CTRL2) begin
			c2 <= wb_dat_i[7:0];
		end else if (wr && wb_adr_i == `SCS_OFF_CTRL1) begin
			c1 <= wb_dat_i[7:0];
		end
	end
	// The receive-pin and break-start checks wait for this to saturate, so up to three register stages in the design are allowed.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			age <= 2'h0;
		else if (wr)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("stray ack");
	chk_read_zero: assert property (req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=>
		wb_dat_o == 32'h0) else $error("unmapped read not zero");
	chk_rx_pin: assert property (age == 2'h3 |-> rx_pin_owned ==
		(c2[`SCS_B_RE] && !c1[`SCS_B_LOOP_MODE_SELECT])) else $error("receive pin ownership");
	chk_brk_pin: assert property (tx_send_break |-> tx_pin_owned)
		else $error("break without pin");
	chk_brk_start: assert property (age == 2'h3 && c2[`SCS_B_SBK] && c2[`SCS_B_TE]
		|-> ##[0:200] tx_send_break) else $error("break not sent");
	chk_mark_wake: assert property (rx_standby && c1[`SCS_B_WAKE] && rx_char_done && msb
		|-> ##[1:3] !rx_standby) else $error("no mark wakeup");
	chk_stby_set: assert property (wr && wb_adr_i == `SCS_OFF_CTRL2 && c1[`SCS_B_WAKE]
		&& wb_dat_i[`SCS_B_RWU] |-> ##[1:2] rx_standby) else $error("no standby");
endmodule
`default_nettype wire

// ===== scs_line_model.sv
// Behavioural model of the frame shifters and serial line beside the block.
`timescale 1ns/100ps
`default_nettype none
module scs_line_model (
	input  wire logic  ref_clk,      // Bus clock.
	input  wire logic  nrst,         // Reset, active low.
	output logic       bit_tick,     // Bit-time pulse.
	output logic       shifter_load, // Shifter takes the byte.
	output logic       shifter_busy, // Frame in progress.
	output logic       rx_char_done, // Character delivered.
	output logic [8:0] rx_char,      // Delivered character.
	output logic       rx_line       // Receive line, idle high.
);
	logic [1:0] div;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div <= 2'h0;
			bit_tick <= 1'b0;
		end else begin
			div <= div + 2'h1;
			bit_tick <= (div == 2'h3);
		end
	end
	initial begin
		shifter_load = 1'b0;
		shifter_busy = 1'b0;
		rx_char_done = 1'b0;
		rx_char = 9'h1ff;
		rx_line = 1'b1;
	end
	// Busy stays up until the caller ends the frame, so both fast and slow frames are possible.
	task automatic load();
		shifter_load <= 1'b1;
		shifter_busy <= 1'b1;
		@(posedge ref_clk);
		shifter_load <= 1'b0;
	endtask
	task automatic unload();
		shifter_busy <= 1'b0;
	endtask
	// The old character is inverted afterwards so that a stale read cannot pass.
	task automatic send_char(input logic [8:0] c);
		rx_line <= 1'b0;
		repeat (36) @(posedge ref_clk);
		rx_line <= 1'b1;
		rx_char <= c;
		rx_char_done <= 1'b1;
		@(posedge ref_clk);
		rx_char_done <= 1'b0;
		rx_char <= ~c;
		@(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// ===== scs_tb.sv
// Self-checking bench for the serial control and status block.
`timescale 1ns/100ps
`default_nettype none
`include "scs_defs.svh"
module testbench;
	logic        ref_clk;
	logic        nrst;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [3:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        bit_tick;
	logic        shifter_load;
	logic        shifter_busy;
	logic        rx_char_done;
	logic [8:0]  rx_char;
	logic        rx_line;
	logic [7:0]  tx_data;
	logic        tx_send_break;
	logic        tx_send_idle;
	logic        tx_pin_owned;
	logic        rx_pin_owned;
	logic        rx_standby;
	logic        irq;
	logic [31:0] rd;
	int          bad_count;
	int          cmp_count;
	int          k;
	scs_ctrl i_scs_ctrl (.*);
	scs_line_model i_scs_line_model (.*);
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb_go(input logic w, input logic [3:0] a, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1) @(posedge ref_clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb_go(1'b0, a, 8'h00);
		chk(nm, rd & m, e);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		repeat (400) if (s !== v) @(posedge ref_clk);
	endtask
	task automatic brk_len(output int n);
		n = 0;
		wait_for(tx_send_break, 1'b1);
		while (tx_send_break === 1'b1) begin
			n += (bit_tick === 1'b1);
			@(posedge ref_clk);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		finish_test();
	end
	initial begin
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h00000000;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rchk("status", `SCS_OFF_STAT1, 32'he0, 32'hc0);
		rchk("ctrl2", `SCS_OFF_CTRL2, 32'hff, 32'h0);
		rchk("unmapped", 4'h1, 32'hffffffff, 32'h0);
		chk("rx_pin", rx_pin_owned, 1'b0);
		wb_go(1'b1, `SCS_OFF_STAT1, 8'h00);
		rchk("status", `SCS_OFF_STAT1, 32'he0, 32'hc0);
		wb_go(1'b1, `SCS_OFF_DATA, 8'h5a);
		rchk("status", `SCS_OFF_STAT1, 32'he0, 32'h00);
		chk("tx_data", tx_data, 8'h5a);
		i_scs_line_model.load();
		rchk("status", `SCS_OFF_STAT1, 32'he0, 32'h80);
		i_scs_line_model.unload();
		repeat (2) @(posedge ref_clk);
		rchk("status", `SCS_OFF_STAT1, 32'he0, 32'hc0);
		$display("transmit test done");
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h04);
		repeat (3) @(posedge ref_clk);
		chk("rx_pin", rx_pin_owned, 1'b1);
		wb_go(1'b1, `SCS_OFF_CTRL1, 8'h04);
		repeat (3) @(posedge ref_clk);
		chk("rx_pin", rx_pin_owned, 1'b0);
		wb_go(1'b1, `SCS_OFF_CTRL1, 8'h00);
		i_scs_line_model.send_char(9'h0a5);
		rchk("data", `SCS_OFF_DATA, 32'h1ff, 32'h0a5);
		rchk("status", `SCS_OFF_STAT1, 32'h20, 32'h20);
		rchk("data", `SCS_OFF_DATA, 32'h1ff, 32'h0a5);
		rchk("status", `SCS_OFF_STAT1, 32'h20, 32'h00);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h24);
		chk("irq", irq, 1'b0);
		i_scs_line_model.send_char(9'h011);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 1'b1);
		rchk("status", `SCS_OFF_STAT1, 32'h20, 32'h20);
		rchk("data", `SCS_OFF_DATA, 32'h1ff, 32'h011);
		wb_go(1'b0, `SCS_OFF_CTRL1, 8'h00);
		chk("irq", irq, 1'b0);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h84);
		repeat (2) @(posedge ref_clk);
		chk("irq", irq, 1'b1);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h04);
		wb_go(1'b0, `SCS_OFF_CTRL1, 8'h00);
		chk("irq", irq, 1'b0);
		$display("receive test done");
		wb_go(1'b1, `SCS_OFF_CTRL1, 8'h08);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h06);
		chk("standby", rx_standby, 1'b1);
		i_scs_line_model.send_char(9'h005);
		chk("standby", rx_standby, 1'b1);
		i_scs_line_model.send_char(9'h085);
		@(posedge ref_clk);
		chk("standby", rx_standby, 1'b0);
		rchk("ctrl2", `SCS_OFF_CTRL2, 32'h02, 32'h00);
		wb_go(1'b1, `SCS_OFF_CTRL1, 8'h00);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h06);
		// The idle count restarts only after line activity, so send a character first.
		i_scs_line_model.send_char(9'h005);
		wait_for(rx_standby, 1'b0);
		chk("standby", rx_standby, 1'b0);
		$display("wakeup test done");
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h08);
		repeat (60) @(posedge ref_clk);
		rchk("status", `SCS_OFF_STAT1, 32'h40, 32'h40);
		for (int i = 0; i < 2; i++) begin
			wb_go(1'b1, `SCS_OFF_CTRL1, i ? 8'h02 : 8'h00);
			fork
				brk_len(k);
				begin
					wb_go(1'b1, `SCS_OFF_CTRL2, 8'h09);
					wb_go(1'b1, `SCS_OFF_CTRL2, 8'h08);
				end
			join
			repeat (150) @(posedge ref_clk);
			chk("break", k == (i ? 13 : 10) || k == (i ? 26 : 20), 1'b1);
		end
		rchk("status", `SCS_OFF_STAT1, 32'h40, 32'h40);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h00);
		wb_go(1'b1, `SCS_OFF_CTRL2, 8'h08);
		wait_for(tx_send_idle, 1'b1);
		chk("idle", tx_send_idle, 1'b1);
		rchk("status", `SCS_OFF_STAT1, 32'h40, 32'h00);
		$display("break test done");
		finish_test();
	end
endmodule
bind scs_ctrl scs_checker i_scs_checker (.*);
`default_nettype wire
